/* File: rtl/ram_block_consts.vh */
// Offsets, field positions, reset values and codes of the RAM block
`ifndef RAM_BLOCK_CONSTS_VH
`define RAM_BLOCK_CONSTS_VH

// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define OFS_CFG        4'h0
`define OFS_STATUS     4'h4
`define OFS_LOAD_ADDR  4'h8
`define OFS_LOAD_DATA  4'hc

// ------------------------------------------------------------------
// Configuration fields
// ------------------------------------------------------------------
`define CFG_MODE_LO    0
`define CFG_MODE_HI    1
`define CFG_WIDTH_LO   2
`define CFG_WIDTH_HI   3
`define CFG_REG_WDATA  4
`define CFG_REG_WADDR  5
`define CFG_REG_WE     6
`define CFG_REG_RADDR  7
`define CFG_REG_RE     8
`define CFG_REG_OUT    9
`define CFG_SPLIT_CLK  10
`define CFG_BITS       11
`define CFG_RESET      11'h001

// ------------------------------------------------------------------
// Modes and widths
// ------------------------------------------------------------------
`define MODE_SINGLE    2'h0
`define MODE_DUAL      2'h1
`define MODE_ROM       2'h2
`define WIDTH_16       2'h0
`define WIDTH_8        2'h1
`define WIDTH_4        2'h2
`define WIDTH_2        2'h3

// ------------------------------------------------------------------
// Bus answers and sizes
// ------------------------------------------------------------------
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`define ARRAY_BITS     4096
`define WORD_BITS      16
`define ROW_COUNT      256

`endif

/* File: rtl/embedded_ram_block.v */
// Configurable 4096-bit embedded RAM block with register access
// Operation
// - Array holds 4096 bits, usable as RAM, ROM, dual-port RAM or FIFO store.
// - RAM shapes: 256x16, 512x8, 1024x4 or 2048x2.
// - Data width per port is at most 16 bits.
// - Single-port or dual-port mode chosen by configuration.
// - Write and read sections advance on independent clock ticks, except in single-port mode or with CFG_SPLIT_CLK set.
// - Each section has its own synchronous clock enable.
// - Optionally input registers on write tick, output register on read tick.
// - Each of six path registers can be inserted or bypassed independently.
// - Every path register clears asynchronously from local or global clear, and synchronously from reset.
// - Write pulse is self-timed from the write tick; user gives addr, data, enable.
// - ROM mode: content preloaded, block serves as a lookup table.
// - One block covers any function of 8 inputs and 16 outputs.
// - Wider memories: blocks side by side on shared address and control.
// - Depth cascade up to 2048 words without timing change.
// - True dual-port memory needs two blocks, not one.
//
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "ram_block_consts.vh"

module embedded_ram_block #(
   parameter AW   = 11,
   parameter DW   = 16,
   parameter ROWS = 256,
   parameter RW   = 8
) (
   input  wire          aclk,
   input  wire          aresetn,
   input  wire          clr_local,
   input  wire          clr_global,
   input  wire          wr_tick,
   input  wire          wr_ce,
   input  wire          wr_en,
   input  wire [AW-1:0] wr_addr,
   input  wire [DW-1:0] wr_data,
   input  wire          rd_tick,
   input  wire          rd_ce,
   input  wire          rd_en,
   input  wire [AW-1:0] rd_addr,
   output wire [DW-1:0] rd_data,
   input  wire [3:0]    s_axi_awaddr,
   input  wire [2:0]    s_axi_awprot,
   input  wire          s_axi_awvalid,
   output wire          s_axi_awready,
   input  wire [31:0]   s_axi_wdata,
   input  wire [3:0]    s_axi_wstrb,
   input  wire          s_axi_wvalid,
   output wire          s_axi_wready,
   output wire [1:0]    s_axi_bresp,
   output wire          s_axi_bvalid,
   input  wire          s_axi_bready,
   input  wire [3:0]    s_axi_araddr,
   input  wire [2:0]    s_axi_arprot,
   input  wire          s_axi_arvalid,
   output wire          s_axi_arready,
   output wire [31:0]   s_axi_rdata,
   output wire [1:0]    s_axi_rresp,
   output wire          s_axi_rvalid,
   input  wire          s_axi_rready
);

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function [DW-1:0] field_mask;
      input [1:0] ws;
      begin
         case (ws)
            `WIDTH_16: field_mask = 16'hffff;
            `WIDTH_8:  field_mask = 16'h00ff;
            `WIDTH_4:  field_mask = 16'h000f;
            default:   field_mask = 16'h0003;
         endcase
      end
   endfunction

   // Bit offset of the addressed lane inside its 16-bit row
   function [3:0] lane_shift;
      input [AW-1:0] a;
      input [1:0]    ws;
      begin
         case (ws)
            `WIDTH_16: lane_shift = 4'h0;
            `WIDTH_8:  lane_shift = {a[0], 3'h0};
            `WIDTH_4:  lane_shift = {a[1:0], 2'h0};
            default:   lane_shift = {a[2:0], 1'b0};
         endcase
      end
   endfunction

   // ---------------------------------------------------------------
   // Configuration and storage
   // ---------------------------------------------------------------
   reg  [`CFG_BITS-1:0] cfg_r;
   reg  [RW-1:0]        load_row_r;
   reg  [DW-1:0]        mem [0:ROWS-1];  // 256 rows of 16 bits

   wire [1:0] mode      = cfg_r[`CFG_MODE_HI:`CFG_MODE_LO];
   wire [1:0] wsel      = cfg_r[`CFG_WIDTH_HI:`CFG_WIDTH_LO];
   wire       is_single = (mode == `MODE_SINGLE);
   wire       is_rom    = (mode == `MODE_ROM);
   wire       split     = cfg_r[`CFG_SPLIT_CLK];

   // ---------------------------------------------------------------
   // Section advance pulses
   // ---------------------------------------------------------------
   wire w_adv = wr_tick & wr_ce;
   wire r_adv_own = rd_tick & rd_ce;
   // Single port runs both sections from the write tick
   wire r_in_adv = (is_single | split) ? w_adv : r_adv_own;
   wire out_adv  = is_single ? w_adv : r_adv_own;

   // ---------------------------------------------------------------
   // Optional path registers
   // ---------------------------------------------------------------
   wire          any_clr = clr_local | clr_global;
   reg  [DW-1:0] wdata_q;
   reg  [AW-1:0] waddr_q;
   reg           we_q;
   reg  [AW-1:0] raddr_q;
   reg           re_q;
   reg  [DW-1:0] core_q;
   reg  [DW-1:0] out_q;

   wire [AW-1:0] rd_addr_src = is_single ? wr_addr : rd_addr;

   wire [DW-1:0] e_wdata = cfg_r[`CFG_REG_WDATA] ? wdata_q : wr_data;
   wire [AW-1:0] e_waddr = cfg_r[`CFG_REG_WADDR] ? waddr_q : wr_addr;
   wire          e_we    = cfg_r[`CFG_REG_WE]    ? we_q    : wr_en;
   wire [AW-1:0] e_raddr = cfg_r[`CFG_REG_RADDR] ? raddr_q
                                                 : rd_addr_src;
   wire          e_re    = cfg_r[`CFG_REG_RE]    ? re_q    : rd_en;

   // ---------------------------------------------------------------
   // Array access
   // ---------------------------------------------------------------
   wire [DW-1:0] fmask = field_mask(wsel);
   wire [AW-1:0] w_row_full = e_waddr >> wsel;
   wire [AW-1:0] r_row_full = e_raddr >> wsel;
   wire [RW-1:0] w_row = w_row_full[RW-1:0];
   // ROM use: low 8 address bits select one of 256 results
   wire [RW-1:0] r_row = r_row_full[RW-1:0];
   wire [3:0]    w_sh  = lane_shift(e_waddr, wsel);
   wire [3:0]    r_sh  = lane_shift(e_raddr, wsel);

   wire [DW-1:0] r_word   = mem[r_row];
   wire [DW-1:0] r_shift  = r_word >> r_sh;
   wire [DW-1:0] rd_field = r_shift & fmask;
   wire [DW-1:0] w_word   = mem[w_row];
   wire [DW-1:0] w_lmask  = fmask << w_sh;
   wire [DW-1:0] w_ins    = (e_wdata & fmask) << w_sh;
   wire [DW-1:0] w_merged = (w_word & ~w_lmask) | w_ins;

   // Pulse exists only on the write tick, so no user timing to the pulse
   wire user_wr = w_adv & e_we & ~is_rom;

   // ---------------------------------------------------------------
   // Combining blocks
   // ---------------------------------------------------------------
   // Side by side: share address and control, join rd_data
   // Depth cascade: decode upper address outside, select rd_data
   // One array write per cycle, so two writers need two blocks
   // Lane sits in low bits, so joined blocks need no realignment

   // ---------------------------------------------------------------
   // Write path registers
   // ---------------------------------------------------------------
   // Clear is asynchronous by design so that many blocks drop together
   always @(posedge aclk or posedge any_clr) begin
      if (any_clr) begin
         wdata_q <= {DW{1'b0}};
      end else if (!aresetn) begin
         wdata_q <= {DW{1'b0}};
      end else if (w_adv) begin
         wdata_q <= wr_data;
      end
   end

   always @(posedge aclk or posedge any_clr) begin
      if (any_clr) begin
         waddr_q <= {AW{1'b0}};
      end else if (!aresetn) begin
         waddr_q <= {AW{1'b0}};
      end else if (w_adv) begin
         waddr_q <= wr_addr;
      end
   end

   always @(posedge aclk or posedge any_clr) begin
      if (any_clr) begin
         we_q <= 1'b0;
      end else if (!aresetn) begin
         we_q <= 1'b0;
      end else if (w_adv) begin
         we_q <= wr_en;
      end
   end

   // ---------------------------------------------------------------
   // Read path registers
   // ---------------------------------------------------------------
   // Bypassed registers still load, so switching one in shows fresh data
   always @(posedge aclk or posedge any_clr) begin
      if (any_clr) begin
         raddr_q <= {AW{1'b0}};
      end else if (!aresetn) begin
         raddr_q <= {AW{1'b0}};
      end else if (r_in_adv) begin
         raddr_q <= rd_addr_src;
      end
   end

   always @(posedge aclk or posedge any_clr) begin
      if (any_clr) begin
         re_q <= 1'b0;
      end else if (!aresetn) begin
         re_q <= 1'b0;
      end else if (r_in_adv) begin
         re_q <= rd_en;
      end
   end

   // Read during a same-edge write returns the old word
   always @(posedge aclk or posedge any_clr) begin
      if (any_clr) begin
         core_q <= {DW{1'b0}};
      end else if (!aresetn) begin
         core_q <= {DW{1'b0}};
      end else if (r_in_adv && e_re) begin
         core_q <= rd_field;
      end
   end

   // ---------------------------------------------------------------
   // Output register
   // ---------------------------------------------------------------
   always @(posedge aclk or posedge any_clr) begin
      if (any_clr) begin
         out_q <= {DW{1'b0}};
      end else if (!aresetn) begin
         out_q <= {DW{1'b0}};
      end else if (out_adv) begin
         out_q <= core_q;
      end
   end

   assign rd_data = cfg_r[`CFG_REG_OUT] ? out_q : core_q;

   // ---------------------------------------------------------------
   // Register bus
   // ---------------------------------------------------------------
   reg        bvalid_r;
   reg [1:0]  bresp_r;
   reg        rvalid_r;
   reg [1:0]  rresp_r;
   reg [31:0] rdata_r;

   // Loads wait while the user writes, so neither write is lost
   wire wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_r & ~user_wr;
   wire rd_go = s_axi_arvalid & ~rvalid_r;
   wire [3:0] wofs = {s_axi_awaddr[3:2], 2'h0};
   wire [3:0] rofs = {s_axi_araddr[3:2], 2'h0};
   wire w_hit = (wofs == `OFS_CFG) | (wofs == `OFS_LOAD_ADDR) |
                (wofs == `OFS_LOAD_DATA);
   wire r_hit = (rofs == `OFS_CFG) | (rofs == `OFS_STATUS) |
                (rofs == `OFS_LOAD_ADDR) | (rofs == `OFS_LOAD_DATA);
   wire load_wr = wr_go & (wofs == `OFS_LOAD_DATA) & s_axi_wstrb[0];

   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = rd_go;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rresp   = rresp_r;
   assign s_axi_rdata   = rdata_r;

   always @(posedge aclk) begin
      if (load_wr) begin
         mem[load_row_r] <= s_axi_wdata[DW-1:0];
      end else if (user_wr) begin
         mem[w_row] <= w_merged;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         cfg_r      <= `CFG_RESET;
         load_row_r <= 8'h00;
         bvalid_r   <= 1'b0;
         bresp_r    <= `RESP_OKAY;
         rvalid_r   <= 1'b0;
         rresp_r    <= `RESP_OKAY;
         rdata_r    <= 32'h0000_0000;
      end else begin
         if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r  <= w_hit ? `RESP_OKAY : `RESP_SLVERR;
            if (s_axi_wstrb[0]) begin
               if (wofs == `OFS_CFG) begin
                  cfg_r[7:0] <= s_axi_wdata[7:0];
               end
               if (wofs == `OFS_LOAD_ADDR) begin
                  load_row_r <= s_axi_wdata[RW-1:0];
               end
               if (wofs == `OFS_LOAD_DATA) begin
                  load_row_r <= load_row_r + 8'h01;
               end
            end
            if (s_axi_wstrb[1] && wofs == `OFS_CFG) begin
               cfg_r[`CFG_BITS-1:8] <= s_axi_wdata[`CFG_BITS-1:8];
            end
         end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
         if (rd_go) begin
            rvalid_r <= 1'b1;
            rresp_r  <= r_hit ? `RESP_OKAY : `RESP_SLVERR;
            case (rofs)
               `OFS_CFG:       rdata_r <= {21'h0, cfg_r};
               `OFS_STATUS:    rdata_r <= {16'h0, rd_data};
               `OFS_LOAD_ADDR: rdata_r <= {24'h0, load_row_r};
               `OFS_LOAD_DATA: rdata_r <= {16'h0, mem[load_row_r]};
               default:        rdata_r <= 32'h0000_0000;
            endcase
         end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
         end
      end
   end

endmodule

/* File: testbench/ram_block_assertions.sv */
// Port checker for the embedded RAM block
`timescale 1ns/1ps
module ram_block_checker (
   input logic        aclk,
   input logic        aresetn,
   input logic        clr_local,
   input logic        clr_global,
   input logic        wr_tick,
   input logic        rd_tick,
   input logic [15:0] rd_data,
   input logic        s_axi_awvalid,
   input logic        s_axi_awready,
   input logic        s_axi_wvalid,
   input logic        s_axi_wready,
   input logic        s_axi_bvalid,
   input logic        s_axi_bready,
   input logic        s_axi_arvalid,
   input logic        s_axi_arready,
   input logic [31:0] s_axi_rdata,
   input logic        s_axi_rvalid,
   input logic        s_axi_rready
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence aw_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence ar_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   resp_follows_a: assert property (aw_take |=> s_axi_bvalid)
      else $error("no write response");
   resp_blocks_a: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write taken during response");
   resp_holds_a: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid) else $error("write response dropped");
   resp_ends_a: assert property (s_axi_bvalid && s_axi_bready
      |=> !s_axi_bvalid) else $error("write response repeated");
   read_answer_a: assert property (ar_take |=> s_axi_rvalid)
      else $error("no read data");
   read_holds_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read lost");
   read_blocks_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken during answer");
   clear_zero_a: assert property (clr_local || clr_global
      |-> rd_data == 16'h0000) else $error("clear did not empty output");
   idle_holds_a: assert property (!wr_tick && !rd_tick
      && !(s_axi_awvalid && s_axi_awready)
      |=> clr_local || clr_global || $stable(rd_data))
      else $error("output moved without a tick");
endmodule
// Implicit named hookup: every checker input matches a port name
bind embedded_ram_block ram_block_checker ram_block_checker_i (.*);

/* File: testbench/fabric_user.sv */
// Fabric-side user logic driving the RAM block user ports
`timescale 1ns/1ps
module fabric_user (
   input  logic        aclk,
   output logic        wr_tick = 1'b0,
   output logic        wr_ce   = 1'b0,
   output logic        wr_en   = 1'b0,
   output logic [10:0] wr_addr = 11'h000,
   output logic [15:0] wr_data = 16'h0000,
   output logic        rd_tick = 1'b0,
   output logic        rd_ce   = 1'b0,
   output logic        rd_en   = 1'b0,
   output logic [10:0] rd_addr = 11'h000
);
   // Address, data and enable held across the tick edge
   task automatic wr(input logic c, e, input logic [10:0] a,
                     input logic [15:0] d);
      wr_tick <= 1'b1;
      wr_ce <= c;
      wr_en <= e;
      wr_addr <= a;
      wr_data <= d;
      @(posedge aclk);
      // Released lines show no stale value
      wr_tick <= 1'b0;
      wr_addr <= ~a;
      wr_data <= ~d;
      @(posedge aclk);
   endtask
   task automatic rd(input logic c, e, input logic [10:0] a);
      rd_tick <= 1'b1;
      rd_ce <= c;
      rd_en <= e;
      rd_addr <= a;
      @(posedge aclk);
      rd_tick <= 1'b0;
      rd_addr <= ~a;
      @(posedge aclk);
   endtask
endmodule

/* File: testbench/embedded_ram_block_bench.sv */
// Self-checking bench for the embedded RAM block
`timescale 1ns/1ps
`include "ram_block_consts.vh"
module embedded_ram_block_bench;
   logic aclk = 1'b0, aresetn = 1'b0, clr_local = 1'b0, clr_global = 1'b0;
   logic wr_tick, wr_ce, wr_en, rd_tick, rd_ce, rd_en;
   logic [10:0] wr_addr, rd_addr;
   logic [15:0] wr_data, rd_data;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
   logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, br;
   int fails = 0, checks_done = 0, cyc = 0;
   fabric_user fabric_user_i (.*);
   embedded_ram_block embedded_ram_block_i (.*);
   always #12.5 aclk = ~aclk;
   // Cuts a hang short; the run needs well under a thousand cycles
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         stop_test;
      end
   end
   task automatic ck(input string n, input logic [31:0] e, s);
      checks_done++;
      if (s !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic axw(input logic [3:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      #1 while (s_axi_awready !== 1'b1) @(posedge aclk) #1;
      @(posedge aclk) s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      #1 while (s_axi_bvalid !== 1'b1) @(posedge aclk) #1;
      // Late bready exercises a waiting response
      @(posedge aclk) s_axi_bready <= 1'b1;
      #1 br = s_axi_bresp;
      @(posedge aclk) s_axi_bready <= 1'b0;
   endtask
   task automatic axr(input logic [3:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      #1 while (s_axi_arready !== 1'b1) @(posedge aclk) #1;
      @(posedge aclk) s_axi_arvalid <= 1'b0;
      #1 while (s_axi_rvalid !== 1'b1) @(posedge aclk) #1;
      @(posedge aclk) s_axi_rready <= 1'b1;
      #1 rv = s_axi_rdata;
      @(posedge aclk) s_axi_rready <= 1'b0;
   endtask
   task automatic urd(input logic [10:0] a, input logic [15:0] e);
      fabric_user_i.rd(1'b1, 1'b1, a);
      ck("rd_data", {16'h0000, e}, {16'h0000, rd_data});
   endtask
   task automatic t_regs;
      axr(`OFS_CFG);
      ck("cfg", {21'h0, `CFG_RESET}, rv);
      // Low address bits are ignored: offset 2 lands on the config word
      axw(4'h2, 32'h0);
      ck("bresp", {30'h0, `RESP_OKAY}, {30'h0, br});
      axr(`OFS_CFG);
      ck("cfg", 32'h0, rv);
   endtask
   task automatic t_shapes;
      logic [10:0] top;
      logic [15:0] m;
      for (int w = 0; w < 4; w++) begin
         top = 11'((`ARRAY_BITS >> (4 - w)) - 1);
         m = 16'hffff >> (16 - (16 >> w));
         axw(`OFS_CFG, {28'h0, w[1:0], `MODE_DUAL});
         fabric_user_i.wr(1'b1, 1'b1, top, 16'ha5c3);
         fabric_user_i.wr(1'b1, 1'b1, top - 11'h1, 16'h5a3c);
         urd(top, 16'ha5c3 & m);
         urd(top - 11'h1, 16'h5a3c & m);
      end
   endtask
   task automatic t_ce;
      axw(`OFS_CFG, 32'h1);
      fabric_user_i.wr(1'b1, 1'b1, 11'h5, 16'h7777);
      fabric_user_i.wr(1'b0, 1'b1, 11'h5, 16'h1111);
      urd(11'h5, 16'h7777);
      fabric_user_i.rd(1'b0, 1'b1, 11'h6);
      ck("rd_data", 32'h7777, {16'h0000, rd_data});
   endtask
   task automatic t_out;
      axw(`OFS_CFG, 32'h201);
      fabric_user_i.rd(1'b1, 1'b1, 11'hfe);
      ck("rd_data", 32'h7777, {16'h0000, rd_data});
      fabric_user_i.rd(1'b1, 1'b0, 11'h0);
      ck("rd_data", 32'h5a3c, {16'h0000, rd_data});
   endtask
   task automatic t_single;
      axw(`OFS_CFG, 32'h0);
      fabric_user_i.rd(1'b0, 1'b1, 11'h0);
      fabric_user_i.wr(1'b1, 1'b1, 11'h9, 16'hbeef);
      fabric_user_i.wr(1'b1, 1'b0, 11'h9, 16'h0000);
      ck("rd_data", 32'hbeef, {16'h0000, rd_data});
   endtask
   task automatic t_rom;
      axw(`OFS_CFG, {30'h0, `MODE_ROM});
      axw(`OFS_LOAD_ADDR, 32'h3);
      axw(`OFS_LOAD_DATA, 32'hc0de);
      axw(`OFS_LOAD_DATA, 32'hf00d);
      fabric_user_i.wr(1'b1, 1'b1, 11'h3, 16'h0000);
      urd(11'h3, 16'hc0de);
      urd(11'h4, 16'hf00d);
      axr(`OFS_STATUS);
      ck("status", 32'hf00d, rv);
   endtask
   task automatic t_clr;
      clr_local <= 1'b1;
      @(posedge aclk) clr_local <= 1'b0;
      ck("rd_data", 32'h0, {16'h0000, rd_data});
      urd(11'h4, 16'hf00d);
      clr_global <= 1'b1;
      @(posedge aclk) clr_global <= 1'b0;
      ck("rd_data", 32'h0, {16'h0000, rd_data});
   endtask
   task automatic stop_test;
      if (fails == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs;
      t_shapes;
      t_ce;
      t_out;
      t_single;
      t_rom;
      t_clr;
      stop_test;
   end
endmodule
